// ### design/dac_link_if.sv
// Carrier for the two open-drain lines between controller and target.
// Assumes pull-ups: a line is low only while some party enables it.
`timescale 1ns/1ps
interface dac_link_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // Wired-AND resolution of the open-drain lines.
  assign scl = scl_m_oe ? scl_m_o : 1'b1;
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);

  modport master (
    output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe,
    input  scl, sda
  );
  modport target (
    output sda_d_o, sda_d_oe,
    input  scl, sda
  );
endinterface

// ### design/dac_link_pkg.sv
// Shared constants and types for the two-wire converter link.
// Assumes both ends and the bench import this package.
package dac_link_pkg;

  // ----------------------------------------------------------------
  // Target addressing and input word layout
  // ----------------------------------------------------------------
  localparam logic [4:0]  ADDR_UPPER     = 5'h03;
  localparam int          DATA_BYTES     = 2;
  localparam logic [15:0] WORD_RESET     = 16'h0000;
  localparam int          SOFT_POWER_DOWN_BIT = 15;
  localparam int          CODE_MSB       = 13;
  localparam int          CODE_LSB       = 4;
  localparam logic [2:0]  LAST_BIT       = 3'h7;
  localparam logic [3:0]  ACK_SLOT       = 4'h8;

  // ----------------------------------------------------------------
  // Controller register map and fields
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_CMD        = 4'h0;
  localparam logic [3:0]  REG_ADDR       = 4'h4;
  localparam logic [3:0]  REG_DATA       = 4'h8;
  localparam logic [3:0]  REG_STATUS     = 4'hC;
  localparam int          CMD_GO_BIT     = 0;
  localparam int          CMD_READ_BIT   = 1;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_NACK_BIT  = 1;
  localparam logic [6:0]  TARGET_RESET   = 7'h0C;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ   = 125;
  localparam int SCL_PERIOD_NS = 2500;
  // Quarter of a serial clock period, rounded up so the rate stays
  // at or below the documented maximum.
  localparam int QUARTER_CYC   =
    (SCL_PERIOD_NS * SYS_CLK_MHZ + 3999) / 4000;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    T_IDLE  = 7'h01,
    T_ADDR  = 7'h02,
    T_ACK_A = 7'h04,
    T_WR    = 7'h08,
    T_ACK_W = 7'h10,
    T_RD    = 7'h20,
    T_ACK_R = 7'h40
  } tgt_state_t;

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BIT   = 4'h4,
    H_STOP  = 4'h8
  } host_state_t;

endpackage

// ### design/dac_master.sv
// Controller end: runs two-byte write and read transactions.
// Assumes software reaches it over a plain register port on sys_clk
// and that the target never stretches the serial clock.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module dac_master
  import dac_link_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  rstn,
  input  wire logic  [3:0] reg_addr,
  input  wire logic  [31:0] reg_wdata,
  input  wire logic  reg_wr,
  input  wire logic  reg_rd,
  output logic [31:0] reg_rdata,
  dac_link_if.master link
);
  import dac_link_pkg::*;

  localparam logic [7:0] Q_LAST = 8'(QUARTER_CYC - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    host_state_t st;
    logic [1:0]  q;
    logic [7:0]  div;
    logic [3:0]  k;
    logic [1:0]  b;
    logic [7:0]  sh;
    logic [15:0] rx;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] data;
    logic        nack;
    logic [31:0] rdata;
    logic        scl_oe;
    logic        sda_oe;
    logic        sda_s1;
    logic        sda_s2;
  } host_regs_t;

  host_regs_t s;
  host_regs_t next_s;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic tick;
    logic own;
    tick = 1'b0;
    own  = 1'b0;
    next_s = s;
    next_s.sda_s1 = link.sda;
    next_s.sda_s2 = s.sda_s1;

    next_s.rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_ADDR:   next_s.rdata = {25'h000_0000, s.addr};
        REG_DATA:   next_s.rdata = {16'h0000, s.data};
        REG_STATUS: next_s.rdata = {30'h0000_0000, s.nack,
                                    s.st != H_IDLE};
        default:    next_s.rdata = 32'h0000_0000;
      endcase
    end

    if (reg_wr) begin
      unique case (reg_addr)
        REG_ADDR: next_s.addr = reg_wdata[6:0];
        REG_DATA: begin
          if (s.st == H_IDLE) begin
            next_s.data = reg_wdata[15:0];
          end
        end
        REG_STATUS: begin
          if (reg_wdata[STAT_NACK_BIT]) begin
            next_s.nack = 1'b0;
          end
        end
        REG_CMD: begin
          if (reg_wdata[CMD_GO_BIT] && s.st == H_IDLE) begin
            next_s.rd  = reg_wdata[CMD_READ_BIT];
            next_s.st  = H_START;
            next_s.q   = 2'h0;
            next_s.div = 8'h00;
          end
        end
        default: next_s.addr = s.addr;
      endcase
    end

    if (s.st != H_IDLE) begin
      tick = (s.div == Q_LAST);
      next_s.div = tick ? 8'h00 : s.div + 8'h01;
    end

    // The target drives data in address ack slots, in write ack slots
    // and in read data slots; the controller owns the rest.
    own = (s.b == 2'h0) || !s.rd;

    if (tick) begin
      next_s.q = s.q + 2'h1;
      unique case (s.st)
        H_IDLE: begin
          next_s.q = 2'h0;
        end
        H_START: begin
          if (s.q == 2'h1) begin
            next_s.sda_oe = 1'b1;
          end
          if (s.q == 2'h3) begin
            next_s.st     = H_BIT;
            next_s.scl_oe = 1'b1;
            next_s.k      = 4'h0;
            next_s.b      = 2'h0;
            next_s.sh     = {s.addr, s.rd};
          end
        end
        H_BIT: begin
          if (s.q == 2'h0) begin
            if (s.k != ACK_SLOT) begin
              next_s.sda_oe = own && !s.sh[7];
            end else begin
              next_s.sda_oe = !own && (s.b == 2'h1);
            end
          end
          if (s.q == 2'h1) begin
            next_s.scl_oe = 1'b0;
          end
          if (s.q == 2'h3) begin
            next_s.scl_oe = 1'b1;
            if (s.k != ACK_SLOT) begin
              next_s.sh = {s.sh[6:0], 1'b0};
              next_s.k  = s.k + 4'h1;
              if (!own) begin
                next_s.rx = {s.rx[14:0], s.sda_s2};
              end
            end else if (own && s.sda_s2) begin
              next_s.nack = 1'b1;
              next_s.st   = H_STOP;
            end else if (s.b == 2'(DATA_BYTES)) begin
              if (s.rd) begin
                next_s.data = s.rx;
              end
              next_s.st = H_STOP;
            end else begin
              next_s.k  = 4'h0;
              next_s.b  = s.b + 2'h1;
              next_s.sh = (s.b == 2'h0) ? s.data[15:8] : s.data[7:0];
            end
          end
        end
        H_STOP: begin
          if (s.q == 2'h0) begin
            next_s.sda_oe = 1'b1;
          end
          if (s.q == 2'h1) begin
            next_s.scl_oe = 1'b0;
          end
          if (s.q == 2'h2) begin
            next_s.sda_oe = 1'b0;
          end
          if (s.q == 2'h3) begin
            next_s.st = H_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s        <= '0;
      s.st     <= H_IDLE;
      s.addr   <= TARGET_RESET;
      s.sda_s1 <= 1'b1;
      s.sda_s2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata     = s.rdata;
  assign link.scl_m_o  = 1'b0;
  assign link.scl_m_oe = s.scl_oe;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = s.sda_oe;

endmodule

// ### design/dac_target.sv
// Serial target end: address match, input word, converter register.
// Assumes it is clocked by the serial clock line itself and that the
// controller idles the clock high between transactions.
`timescale 1ns/1ps

module dac_target
  import dac_link_pkg::*;
(
  dac_link_if.target link,
  input  wire logic  rstn,
  input  wire logic  power_down_pin,
  output logic [9:0] converter_code_bits,
  output logic       power_down
);
  import dac_link_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    tgt_state_t  st;
    logic [2:0]  cnt;
    logic [7:0]  sh;
    logic        idx;
    logic        rw;
    logic        sta_seen;
    logic        sto_seen;
    logic [15:0] dac_input_word;
    logic [15:0] dac_reg;
  } tgt_regs_t;

  tgt_regs_t s;
  tgt_regs_t next_s;
  logic      sta_tog;
  logic      sto_tog;
  logic      sda_n;
  logic      sda_drive;

  // ----------------------------------------------------------------
  // Start and stop detection
  // ----------------------------------------------------------------
  // These conditions happen while the clock is high, so no clock edge
  // of this end can see them; a toggle per condition carries them.
  assign sda_n = ~link.sda;

  line_edge_toggle u_start (
    .edge_in    (link.sda),
    .level_high (link.scl),
    .rstn       (rstn),
    .toggle     (sta_tog)
  );

  line_edge_toggle u_stop (
    .edge_in    (sda_n),
    .level_high (link.scl),
    .rstn       (rstn),
    .toggle     (sto_tog)
  );

  // ----------------------------------------------------------------
  // Next-state logic, evaluated for the rising clock edge
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (sta_tog != s.sta_seen) begin
      next_s.sta_seen = sta_tog;
      next_s.sto_seen = sto_tog;
      next_s.st       = T_ADDR;
      next_s.cnt      = 3'h1;
      next_s.idx      = 1'b0;
      // The rising edge that reveals the start also clocks the first
      // address bit, so it must be shifted here or the byte slips.
      next_s.sh       = {s.sh[6:0], link.sda};
    end else if (sto_tog != s.sto_seen) begin
      next_s.sto_seen = sto_tog;
      next_s.st       = T_IDLE;
    end else begin
      unique case (s.st)
        T_IDLE: begin
          next_s.st = T_IDLE;
        end
        T_ADDR: begin
          next_s.sh  = {s.sh[6:0], link.sda};
          next_s.cnt = s.cnt + 3'h1;
          if (s.cnt == LAST_BIT) begin
            next_s.rw = link.sda;
            if (s.sh[6:2] == ADDR_UPPER) begin
              next_s.st = T_ACK_A;
            end else begin
              next_s.st = T_IDLE;
            end
          end
        end
        T_ACK_A: begin
          next_s.cnt = 3'h0;
          next_s.idx = 1'b0;
          if (s.rw) begin
            next_s.sh = s.dac_input_word[15:8];
            next_s.st = T_RD;
          end else begin
            next_s.st = T_WR;
          end
        end
        T_WR: begin
          next_s.sh  = {s.sh[6:0], link.sda};
          next_s.cnt = s.cnt + 3'h1;
          if (s.cnt == LAST_BIT) begin
            if (!s.idx) begin
              next_s.dac_input_word[15:8] = {s.sh[6:0], link.sda};
            end else begin
              next_s.dac_input_word[7:0] = {s.sh[6:0], link.sda};
            end
            next_s.st = T_ACK_W;
          end
        end
        T_ACK_W: begin
          next_s.cnt = 3'h0;
          if (s.idx) begin
            next_s.dac_reg = s.dac_input_word;
            next_s.st = T_IDLE;
          end else begin
            next_s.idx = 1'b1;
            next_s.st  = T_WR;
          end
        end
        T_RD: begin
          next_s.sh  = {s.sh[6:0], 1'b0};
          next_s.cnt = s.cnt + 3'h1;
          if (s.cnt == LAST_BIT) begin
            next_s.st = T_ACK_R;
          end
        end
        T_ACK_R: begin
          next_s.cnt = 3'h0;
          if (s.idx) begin
            next_s.dac_input_word = WORD_RESET;
            next_s.st = T_IDLE;
          end else if (!link.sda) begin
            next_s.idx = 1'b1;
            next_s.sh  = s.dac_input_word[7:0];
            next_s.st  = T_RD;
          end else begin
            next_s.st = T_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers on the rising serial clock
  // ----------------------------------------------------------------
  always_ff @(posedge link.scl or negedge rstn) begin
    if (!rstn) begin
      s.st             <= T_IDLE;
      s.cnt            <= 3'h0;
      s.sh             <= 8'h00;
      s.idx            <= 1'b0;
      s.rw             <= 1'b0;
      s.sta_seen       <= 1'b0;
      s.sto_seen       <= 1'b0;
      s.dac_input_word <= WORD_RESET;
      s.dac_reg        <= WORD_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Data line driver on the falling serial clock
  // ----------------------------------------------------------------
  // change only clock-low
  always_ff @(negedge link.scl or negedge rstn) begin
    if (!rstn) begin
      sda_drive <= 1'b0;
    end else begin
      sda_drive <= (s.st == T_ACK_A) || (s.st == T_ACK_W) ||
                   ((s.st == T_RD) && !s.sh[7]);
    end
  end

  assign link.sda_d_o  = 1'b0;
  assign link.sda_d_oe = sda_drive;

  // ----------------------------------------------------------------
  // Converter outputs
  // ----------------------------------------------------------------
  // code field
  assign converter_code_bits = s.dac_reg[CODE_MSB:CODE_LSB];
  // soft bit or pin; the pin needs no serial clock at all.
  assign power_down = power_down_pin | s.dac_reg[SOFT_POWER_DOWN_BIT];

endmodule

// ### design/line_edge_toggle.sv
// Flags a data-line edge seen while the clock line is high.
// Assumes the edge is followed by a full clock low phase before the
// reader's next rising clock edge, which makes the toggle safe to read.
`timescale 1ns/1ps
module line_edge_toggle (
  input  wire logic edge_in,
  input  wire logic level_high,
  input  wire logic rstn,
  output logic      toggle
);
  // A falling edge of edge_in while level_high flips the toggle.
  always_ff @(negedge edge_in or negedge rstn) begin
    if (!rstn) begin
      toggle <= 1'b0;
    end else if (level_high) begin
      toggle <= ~toggle;
    end
  end
endmodule

// ### sim/dac_link_sva.sv
// Checker for the two open-drain lines between controller and target.
// Assumes it sits beside the carrier and samples the lines on sys_clk.
`timescale 1ns/1ps
module dac_link_sva (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // A clock high phase longer than any bit slot marks an idle bus.
  logic [9:0] hi_cnt;
  logic [4:0] rise_cnt;
  logic       sda_q;
  logic       scl_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt   <= 10'h000;
      rise_cnt <= 5'h00;
      sda_q    <= 1'b1;
      scl_q    <= 1'b1;
    end else begin
      sda_q <= sda;
      scl_q <= scl;
      if (!scl) begin
        hi_cnt <= 10'h000;
      end else if (hi_cnt != 10'h3FF) begin
        hi_cnt <= hi_cnt + 10'h001;
      end
      if (scl && sda_q && !sda) begin
        rise_cnt <= 5'h00;
      end else if (scl && !scl_q) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence start_s;
    scl && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $rose(sda);
  endsequence
  sequence lines_idle_s;
    (scl && sda) [*8];
  endsequence

  AST_SCL_PULL_ONLY: assert property (
    scl_m_oe |-> !scl_m_o) else $error("clock driven high");
  AST_SDA_PULL_ONLY: assert property (
    !(sda_m_oe && sda_m_o) && !(sda_d_oe && sda_d_o))
    else $error("data driven high");
  AST_IDLE_RELEASED: assert property (
    hi_cnt > 10'h0F0 |-> !sda_d_oe) else $error("target pulls idle bus");
  AST_DEV_EDGE_LOW: assert property (
    $changed(sda_d_oe) |-> !scl) else $error("target data moved, clock high");
  AST_ACK_HELD: assert property (
    $rose(scl) && sda_d_oe |-> (sda_d_oe && !sda) [*8])
    else $error("acknowledge not held in clock pulse");
  AST_START_FIRST: assert property (
    $fell(scl) && hi_cnt > 10'h0F0 |-> !sda)
    else $error("clocking began without start");
  AST_START_CLOCKS: assert property (
    start_s |-> ##[1:400] $fell(scl)) else $error("no clocks after start");
  AST_STOP_IDLE: assert property (
    stop_s |=> lines_idle_s) else $error("bus not idle after stop");
  AST_TWO_BYTES: assert property (
    stop_s |-> rise_cnt == 5'h1C || rise_cnt == 5'h0A)
    else $error("wrong clock count between start and stop");
endmodule

// ### sim/i2c_current_dac_write_port_bench.sv
// Bench joining controller and target through the two-wire carrier.
// Assumes the package, carrier, both ends and the checker compile first.
`timescale 1ns/1ps
module i2c_current_dac_write_port_bench;
  import dac_link_pkg::*;
  logic        sys_clk;
  logic        rstn;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        rd_chk;
  logic        rd_seen;
  logic [31:0] reg_rdata;
  logic        power_down_pin;
  logic [9:0]  converter_code_bits;
  logic        power_down;
  logic [31:0] seed;
  logic [15:0] w;
  logic [9:0]  code_now;
  logic [31:0] exp_q[$];
  int          miscompares;
  int          checked;

  dac_link_if link ();
  dac_master u_dac_master (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link));
  dac_target u_dac_target (.link(link), .rstn(rstn),
    .power_down_pin(power_down_pin),
    .converter_code_bits(converter_code_bits), .power_down(power_down));
  dac_link_sva u_dac_link_sva (.sys_clk(sys_clk), .rstn(rstn),
    .scl_m_o(link.scl_m_o), .scl_m_oe(link.scl_m_oe),
    .sda_m_o(link.sda_m_o), .sda_m_oe(link.sda_m_oe),
    .sda_d_o(link.sda_d_o), .sda_d_oe(link.sda_d_oe),
    .scl(link.scl), .sda(link.sda));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    checked++;
    if (seen !== expd) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Register port driver and read-back watcher
  // ----------------------------------------------------------------
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [31:0] e,
                          input logic chk);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rd_chk   <= chk;
    if (chk) begin
      exp_q.push_back(e);
    end
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
  endtask

  always @(posedge sys_clk) begin
    rd_seen <= reg_rd && rd_chk;
  end
  always @(negedge sys_clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      check(reg_rdata, exp_q.pop_front());
    end
  end

  // A whole transfer, with the converter checked while it is in flight.
  task automatic transfer(input logic [6:0] ta, input logic rd,
                          input logic [15:0] d);
    logic busy;
    busy = 1'b1;
    reg_write(REG_ADDR, {25'h0, ta});
    if (!rd) begin
      reg_write(REG_DATA, {16'h0, d});
    end
    reg_write(REG_CMD, {30'h0, rd, 1'b1});
    repeat (2000) @(posedge sys_clk);
    check(converter_code_bits, code_now);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
      repeat (40) @(posedge sys_clk);
      reg_read(REG_STATUS, 32'h0, 1'b0);
      @(negedge sys_clk);
      busy = reg_rdata[STAT_BUSY_BIT];
    end
    check(busy, 1'b0);
  endtask

  initial begin
    watchdog_span();
  end
  task automatic watchdog_span();
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    tally_and_finish();
  endtask

  initial begin
    rstn      = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    rd_chk    = 1'b0;
    power_down_pin = 1'b0;
    seed      = 32'd38;
    code_now  = 10'h000;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    reg_read(REG_ADDR, {25'h0, TARGET_RESET}, 1'b1);
    reg_read(REG_CMD, 32'h0000_0000, 1'b1);
    reg_read(4'h2, 32'h0000_0000, 1'b1);
    check(converter_code_bits, 10'h000);
    $display("test reset done");

    seed = xorshift(seed);
    w = seed[15:0] & 16'h7FFF;
    transfer({ADDR_UPPER, seed[17:16]}, 1'b0, w);
    code_now = w[CODE_MSB:CODE_LSB];
    check(converter_code_bits, code_now);
    check(power_down, 1'b0);
    reg_read(REG_STATUS, 32'h0000_0000, 1'b1);
    reg_read(REG_DATA, {16'h0, w}, 1'b1);
    $display("test write done");

    transfer(7'h0D, 1'b1, 16'h0000);
    reg_read(REG_DATA, {16'h0, w}, 1'b1);
    reg_read(REG_STATUS, 32'h0000_0000, 1'b1);
    transfer(7'h0E, 1'b1, 16'h0000);
    reg_read(REG_DATA, 32'h0000_0000, 1'b1);
    check(converter_code_bits, code_now);
    $display("test read done");

    seed = xorshift(seed);
    transfer(7'h08, 1'b0, seed[15:0]);
    check(converter_code_bits, code_now);
    reg_read(REG_STATUS, 32'h0000_0002, 1'b1);
    reg_write(REG_STATUS, 32'h0000_0002);
    reg_read(REG_STATUS, 32'h0000_0000, 1'b1);
    $display("test mismatch done");

    @(posedge sys_clk);
    power_down_pin <= 1'b1;
    @(negedge sys_clk);
    check(power_down, 1'b1);
    @(posedge sys_clk);
    power_down_pin <= 1'b0;
    @(negedge sys_clk);
    check(power_down, 1'b0);
    seed = xorshift(seed);
    w = seed[15:0] | 16'h8000;
    transfer(7'h0F, 1'b0, w);
    code_now = w[CODE_MSB:CODE_LSB];
    check(converter_code_bits, code_now);
    check(power_down, 1'b1);
    $display("test power down done");
    repeat (4) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule
